// *** pkg/pdm_mic_pkg.sv ***
// Types shared by the microphone capture control block.
// Assumes the constants header is included by each user.
package pdm_mic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DRAIN = 3'b100
  } capture_state_t;
  typedef logic [15:0] sample_t;
  typedef logic [6:0]  gain_t;
  typedef logic [2:0]  event_vec_t;
endpackage

// *** pkg/pdm_mic_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// for the microphone capture control block.
// Assumes paddr carries a 12-bit byte offset inside the block.
// Notes on behaviour
// - End event once the last counted sample, or last after stop, is in RAM.
// - Writing one to enable-set enables that interrupt; reads return enables.
// - Writing one to enable-clear disables that interrupt; reads same enables.
// - Module enable bit 0 switches interface off, 1 on; off after reset.
// - Stereo mode 0 packs right in [31:16], left in [15:0].
// - Mono mode 1 packs earlier left in [15:0], later left in [31:16].
// - Edge field 0 samples left on falling edge, 1 on rising; right opposite.
// - Left gain in 0.5 dB steps; code 0x28 means no change and is reset value; logic multiplies by the code instead.
// - Left gain codes run 0x00 (-20 dB) to 0x50 (+20 dB).
// - Start trigger begins continuous capture to memory; stop ends it.
// - Started flag set when transfer begins, stopped flag when finished.
// - Samples go to successive RAM words from the programmed pointer.
`ifndef PDM_MIC_REGS_SVH
`define PDM_MIC_REGS_SVH

`define OFS_TASK_START   12'h000
`define OFS_TASK_STOP    12'h004
`define OFS_EVT_STARTED  12'h100
`define OFS_EVT_STOPPED  12'h104
`define OFS_EVT_END      12'h108
`define OFS_IRQ_MASK     12'h300
`define OFS_IRQ_SET      12'h304
`define OFS_IRQ_CLR      12'h308
`define OFS_IRQ_STATUS   12'h30c
`define OFS_MOD_EN       12'h500
`define OFS_CLK_CTRL     12'h504
`define OFS_ROUTING      12'h508
`define OFS_GAIN_L       12'h518
`define OFS_RAM_PTR      12'h560
`define OFS_CNT_LIMIT    12'h564

`define EVT_STARTED_BIT  0
`define EVT_STOPPED_BIT  1
`define EVT_END_BIT      2
`define ROUTE_MONO_BIT   0
`define ROUTE_EDGE_BIT   1

`define GAIN_RST         7'h28
`define GAIN_LOWEST      7'h00
`define GAIN_HIGHEST     7'h50
`define DENSITY_CENTRE   8'h20
`define WINDOW_LAST      6'h3f
`define CNT_STEP         15'h0002
`define ADDR_STEP        32'h00000004

`define SYS_PERIOD_NS    40
`define MIC_PERIOD_NS    320
`define MIC_HALF_CYC \
  ((`MIC_PERIOD_NS / 2 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

`endif

// *** src/pdm_channel_accum.sv ***
// One channel: counts ones over a window of 64 mic bits, centres and
// scales the density by a gain code into a 16-bit sample.
// Assumes bitStrobe is a one-cycle pulse on clk_sys.
`timescale 1ns/10ps
`include "pdm_mic_regs.svh"
module pdm_channel_accum (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // Bit stream
  input  wire logic                 clear,
  input  wire logic                 bitStrobe,
  input  wire logic                 bitIn,
  input  wire pdm_mic_pkg::gain_t   gainCode,
  // Sample out
  output logic                      sampleStrobe,
  output pdm_mic_pkg::sample_t      sampleOut
);
  import pdm_mic_pkg::*;

  logic [6:0]  ones_r;
  logic [6:0]  ones_nxt;
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_nxt;
  sample_t     sample_r;
  sample_t     sample_nxt;
  logic        strobe_r;
  logic        strobe_nxt;
  logic [6:0]  onesAll;
  logic signed [7:0]  centred;
  logic signed [15:0] scaled;

  // Linear scaling stands in for the dB law; code 0x28 multiplies the centred count by 40
  assign onesAll = ones_r + {6'h00, bitIn};
  assign centred = $signed({1'b0, onesAll}) - $signed(`DENSITY_CENTRE);
  assign scaled  = 16'(centred) * $signed({9'h000, gainCode});

  always_comb begin
    ones_nxt   = ones_r;
    cnt_nxt    = cnt_r;
    sample_nxt = sample_r;
    strobe_nxt = 1'b0;
    if (clear) begin
      ones_nxt = 7'h00;
      cnt_nxt  = 6'h00;
    end else if (bitStrobe) begin
      cnt_nxt = cnt_r + 6'h01;
      if (cnt_r == `WINDOW_LAST) begin
        ones_nxt   = 7'h00;
        sample_nxt = scaled;
        strobe_nxt = 1'b1;
      end else begin
        ones_nxt = onesAll;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ones_r   <= 7'h00;
      cnt_r    <= 6'h00;
      sample_r <= 16'h0000;
      strobe_r <= 1'b0;
    end else begin
      ones_r   <= ones_nxt;
      cnt_r    <= cnt_nxt;
      sample_r <= sample_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  assign sampleStrobe = strobe_r;
  assign sampleOut    = sample_r;
endmodule

// *** src/pdm_mic_capture_control.sv ***
// Capture control for PDM microphones: APB registers, mic clock
// divider, channel packing into RAM words, events and interrupt.
// Assumes a memory port on clk_sys that acknowledges each word.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "pdm_mic_regs.svh"
module pdm_mic_capture_control (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Microphone pins
  output logic               micBitClock,
  input  wire logic          micDataIn,
  // Sample memory port
  output logic               memWrReq,
  output logic [31:0]        memWrAddr,
  output logic [31:0]        memWrData,
  input  wire logic          memWrAck,
  // Interrupt
  output logic               irq
);
  import pdm_mic_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // APB decode
  logic        setupPh;
  logic        accessWr;
  logic        accessRd;
  logic        mapped;
  logic [31:0] rdValue;

  assign setupPh  = psel & ~penable;
  assign accessWr = psel & penable & pwrite;
  assign accessRd = psel & penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic        enable_r;
  logic        enable_nxt;
  event_vec_t  irqMask_r;
  event_vec_t  irqMask_nxt;
  logic [7:0]  clkHalf_r;
  logic [7:0]  clkHalf_nxt;
  logic        monoMode_r;
  logic        monoMode_nxt;
  logic        leftOnRise_r;
  logic        leftOnRise_nxt;
  gain_t       gainLeft_r;
  gain_t       gainLeft_nxt;
  logic [31:0] ramPtr_r;
  logic [31:0] ramPtr_nxt;
  logic [14:0] cntLimit_r;
  logic [14:0] cntLimit_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic        wrHit;
  logic        startTask;
  logic        stopTask;

  assign wrHit     = accessWr & (paddr[1:0] == 2'b00);
  assign startTask = wrHit & (paddr == `OFS_TASK_START) & pwdata[0];
  assign stopTask  = wrHit & (paddr == `OFS_TASK_STOP) & pwdata[0];

  always_comb begin
    enable_nxt     = enable_r;
    irqMask_nxt    = irqMask_r;
    clkHalf_nxt    = clkHalf_r;
    monoMode_nxt   = monoMode_r;
    leftOnRise_nxt = leftOnRise_r;
    gainLeft_nxt   = gainLeft_r;
    ramPtr_nxt     = ramPtr_r;
    cntLimit_nxt   = cntLimit_r;
    prdata_nxt     = prdata_r;
    if (setupPh) begin
      prdata_nxt = rdValue;
    end
    if (wrHit) begin
      unique case (paddr)
        `OFS_IRQ_MASK:  irqMask_nxt = pwdata[2:0];
        `OFS_IRQ_SET:   irqMask_nxt = irqMask_r | pwdata[2:0];
        `OFS_IRQ_CLR:   irqMask_nxt = irqMask_r & ~pwdata[2:0];
        `OFS_MOD_EN:    enable_nxt = pwdata[0];
        `OFS_CLK_CTRL:  clkHalf_nxt = pwdata[7:0];
        `OFS_ROUTING: begin
          monoMode_nxt   = pwdata[`ROUTE_MONO_BIT];
          leftOnRise_nxt = pwdata[`ROUTE_EDGE_BIT];
        end
        `OFS_GAIN_L:    gainLeft_nxt = pwdata[6:0];
        `OFS_RAM_PTR:   ramPtr_nxt = pwdata;
        `OFS_CNT_LIMIT: cntLimit_nxt = pwdata[14:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_r     <= 1'b0;
      irqMask_r    <= 3'h0;
      clkHalf_r    <= 8'(`MIC_HALF_CYC);
      monoMode_r   <= 1'b0;
      leftOnRise_r <= 1'b0;
      gainLeft_r   <= `GAIN_RST;
      ramPtr_r     <= 32'h00000000;
      cntLimit_r   <= 15'h0000;
      prdata_r     <= 32'h00000000;
    end else begin
      enable_r     <= enable_nxt;
      irqMask_r    <= irqMask_nxt;
      clkHalf_r    <= clkHalf_nxt;
      monoMode_r   <= monoMode_nxt;
      leftOnRise_r <= leftOnRise_nxt;
      gainLeft_r   <= gainLeft_nxt;
      ramPtr_r     <= ramPtr_nxt;
      cntLimit_r   <= cntLimit_nxt;
      prdata_r     <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux and event flags
  event_vec_t  evt_r;
  event_vec_t  evt_nxt;
  event_vec_t  evtSet;
  event_vec_t  evtClr;

  always_comb begin
    rdValue = 32'h00000000;
    mapped  = (paddr[1:0] == 2'b00);
    unique case (paddr)
      `OFS_TASK_START,
      `OFS_TASK_STOP:   rdValue = 32'h00000000;
      `OFS_EVT_STARTED: rdValue = {31'h0, evt_r[`EVT_STARTED_BIT]};
      `OFS_EVT_STOPPED: rdValue = {31'h0, evt_r[`EVT_STOPPED_BIT]};
      `OFS_EVT_END:     rdValue = {31'h0, evt_r[`EVT_END_BIT]};
      `OFS_IRQ_MASK,
      `OFS_IRQ_SET,
      `OFS_IRQ_CLR:     rdValue = {29'h0, irqMask_r};
      `OFS_IRQ_STATUS:  rdValue = {29'h0, evt_r};
      `OFS_MOD_EN:      rdValue = {31'h0, enable_r};
      `OFS_CLK_CTRL:    rdValue = {24'h0, clkHalf_r};
      `OFS_ROUTING:     rdValue = {30'h0, leftOnRise_r, monoMode_r};
      `OFS_GAIN_L:      rdValue = {25'h0, gainLeft_r};
      `OFS_RAM_PTR:     rdValue = ramPtr_r;
      `OFS_CNT_LIMIT:   rdValue = {17'h0, cntLimit_r};
      default:          mapped = 1'b0;
    endcase
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // A read clears only the bits it reported, so a flag set between setup
  // and access is not lost; a write of zero clears too
  logic        flagClr;
  assign flagClr = accessRd ? prdata_r[0] : (wrHit & ~pwdata[0]);
  always_comb begin
    evtClr = 3'h0;
    if (accessRd & (paddr == `OFS_IRQ_STATUS)) begin
      evtClr = prdata_r[2:0];
    end
    if (flagClr & (paddr == `OFS_EVT_STARTED)) begin
      evtClr[`EVT_STARTED_BIT] = 1'b1;
    end
    if (flagClr & (paddr == `OFS_EVT_STOPPED)) begin
      evtClr[`EVT_STOPPED_BIT] = 1'b1;
    end
    if (flagClr & (paddr == `OFS_EVT_END)) begin
      evtClr[`EVT_END_BIT] = 1'b1;
    end
    evt_nxt = (evt_r & ~evtClr) | evtSet;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      evt_r <= 3'h0;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign irq = |(evt_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////
  // Mic clock divider and data synchroniser
  capture_state_t state_r;
  capture_state_t state_nxt;
  logic        running;
  logic [7:0]  div_r;
  logic [7:0]  div_nxt;
  logic        micClk_r;
  logic        micClk_nxt;
  logic        dataMeta_r;
  logic        dataSync_r;
  logic        riseNow;
  logic        fallNow;
  logic        toggleNow;
  logic        leftStrobe;
  logic        rightStrobe;

  assign running   = enable_r & (state_r == ST_RUN);
  assign toggleNow = running & ((div_r + 8'h01) >= clkHalf_r);
  assign riseNow   = toggleNow & ~micClk_r;
  assign fallNow   = toggleNow & micClk_r;
  // Sampled right at the edge; the pin value is two cycles old
  assign leftStrobe  = leftOnRise_r ? riseNow : fallNow;
  assign rightStrobe = leftOnRise_r ? fallNow : riseNow;

  always_comb begin
    div_nxt    = div_r + 8'h01;
    micClk_nxt = micClk_r;
    if (!running) begin
      div_nxt    = 8'h00;
      micClk_nxt = 1'b0;
    end else if (toggleNow) begin
      div_nxt    = 8'h00;
      micClk_nxt = ~micClk_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_r      <= 8'h00;
      micClk_r   <= 1'b0;
      dataMeta_r <= 1'b0;
      dataSync_r <= 1'b0;
    end else begin
      div_r      <= div_nxt;
      micClk_r   <= micClk_nxt;
      dataMeta_r <= micDataIn;
      dataSync_r <= dataMeta_r;
    end
  end

  assign micBitClock = micClk_r;

  ////////////////////////////////////////////////////////////////////
  // Channel accumulators
  logic        leftValid;
  logic        rightValid;
  sample_t     leftSample;
  sample_t     rightSample;

  pdm_channel_accum u_left (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .clear        (~running),
    .bitStrobe    (leftStrobe),
    .bitIn        (dataSync_r),
    .gainCode     (gainLeft_r),
    .sampleStrobe (leftValid),
    .sampleOut    (leftSample)
  );

  // Right gain is not adjustable here; it runs at the reset code 0x28, a multiply by 40
  pdm_channel_accum u_right (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .clear        (~running),
    .bitStrobe    (rightStrobe),
    .bitIn        (dataSync_r),
    .gainCode     (`GAIN_RST),
    .sampleStrobe (rightValid),
    .sampleOut    (rightSample)
  );

  ////////////////////////////////////////////////////////////////////
  // Packing, memory writes and capture sequence
  sample_t     lowHalf_r;
  sample_t     lowHalf_nxt;
  sample_t     highHalf_r;
  sample_t     highHalf_nxt;
  logic        lowSeen_r;
  logic        lowSeen_nxt;
  logic        highSeen_r;
  logic        highSeen_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic        last_r;
  logic        last_nxt;
  logic [31:0] wAddr_r;
  logic [31:0] wAddr_nxt;
  logic [31:0] wData_r;
  logic [31:0] wData_nxt;
  logic [31:0] addrCur_r;
  logic [31:0] addrCur_nxt;
  logic [14:0] cnt_r;
  logic [14:0] cnt_nxt;
  logic        push;
  logic [31:0] pushWord;
  logic        acked;

  assign acked = pend_r & memWrAck;

  always_comb begin
    state_nxt    = state_r;
    lowHalf_nxt  = lowHalf_r;
    highHalf_nxt = highHalf_r;
    lowSeen_nxt  = lowSeen_r;
    highSeen_nxt = highSeen_r;
    pend_nxt     = pend_r & ~acked;
    last_nxt     = last_r;
    wAddr_nxt    = wAddr_r;
    wData_nxt    = wData_r;
    addrCur_nxt  = addrCur_r;
    cnt_nxt      = cnt_r;
    push         = 1'b0;
    pushWord     = {highHalf_r, lowHalf_r};
    evtSet       = 3'h0;
    if (acked & last_r) begin
      evtSet[`EVT_END_BIT] = 1'b1;
    end
    if (monoMode_r) begin
      if (leftValid & lowSeen_r) begin
        push        = 1'b1;
        pushWord    = {leftSample, lowHalf_r};
        lowSeen_nxt = 1'b0;
      end else if (leftValid) begin
        lowHalf_nxt = leftSample;
        lowSeen_nxt = 1'b1;
      end
    end else begin
      if (leftValid) begin
        lowHalf_nxt = leftSample;
        lowSeen_nxt = 1'b1;
      end
      if (rightValid) begin
        highHalf_nxt = rightSample;
        highSeen_nxt = 1'b1;
      end
      if (lowSeen_nxt & highSeen_nxt) begin
        push         = 1'b1;
        pushWord     = {highHalf_nxt, lowHalf_nxt};
        lowSeen_nxt  = 1'b0;
        highSeen_nxt = 1'b0;
      end
    end
    // Words arriving while one is still unacknowledged are dropped
    if (push & running & ~pend_r) begin
      pend_nxt    = 1'b1;
      wData_nxt   = pushWord;
      wAddr_nxt   = addrCur_r;
      addrCur_nxt = addrCur_r + `ADDR_STEP;
      cnt_nxt     = cnt_r + `CNT_STEP;
      last_nxt    = (cnt_nxt >= cntLimit_r);
      if (last_nxt) begin
        addrCur_nxt = ramPtr_r;
        cnt_nxt     = 15'h0000;
      end
    end
    unique case (state_r)
      ST_IDLE: begin
        if (startTask & enable_r) begin
          state_nxt   = ST_RUN;
          addrCur_nxt = ramPtr_r;
          cnt_nxt     = 15'h0000;
          lowSeen_nxt = 1'b0;
          highSeen_nxt = 1'b0;
          evtSet[`EVT_STARTED_BIT] = 1'b1;
        end
      end
      ST_RUN: begin
        if (stopTask) begin
          state_nxt = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (~pend_r | acked) begin
          state_nxt = ST_IDLE;
          evtSet[`EVT_END_BIT]     = 1'b1;
          evtSet[`EVT_STOPPED_BIT] = 1'b1;
        end
      end
    endcase
    if (!enable_r) begin
      state_nxt = ST_IDLE;
      pend_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_IDLE;
      lowHalf_r  <= 16'h0000;
      highHalf_r <= 16'h0000;
      lowSeen_r  <= 1'b0;
      highSeen_r <= 1'b0;
      pend_r     <= 1'b0;
      last_r     <= 1'b0;
      wAddr_r    <= 32'h00000000;
      wData_r    <= 32'h00000000;
      addrCur_r  <= 32'h00000000;
      cnt_r      <= 15'h0000;
    end else begin
      state_r    <= state_nxt;
      lowHalf_r  <= lowHalf_nxt;
      highHalf_r <= highHalf_nxt;
      lowSeen_r  <= lowSeen_nxt;
      highSeen_r <= highSeen_nxt;
      pend_r     <= pend_nxt;
      last_r     <= last_nxt;
      wAddr_r    <= wAddr_nxt;
      wData_r    <= wData_nxt;
      addrCur_r  <= addrCur_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  assign memWrReq  = pend_r;
  assign memWrAddr = wAddr_r;
  assign memWrData = wData_r;
endmodule

// *** tb/pdm_mic_checker.sv ***
// Port-level checks on the capture control block.
// Assumes zero-wait APB and offsets from the shared header.
`timescale 1ns/10ps
`include "pdm_mic_regs.svh"
module pdm_mic_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Mic, memory, interrupt
  input wire logic        micBitClock,
  input wire logic        micDataIn,
  input wire logic        memWrReq,
  input wire logic [31:0] memWrAddr,
  input wire logic [31:0] memWrData,
  input wire logic        memWrAck,
  input wire logic        irq
);
  logic [2:0] mask_r, mask_nxt;
  logic       en_r, en_nxt;
  logic [1:0] route_r, route_nxt;
  logic [6:0] gain_r, gain_nxt;
  logic       wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  //////////////////////////////////////////////////////////////////////
  // Shadow of the mask, enable, routing and gain registers
  always_comb begin
    mask_nxt = mask_r;
    en_nxt = en_r;
    route_nxt = route_r;
    gain_nxt = gain_r;
    if (wr && paddr == `OFS_IRQ_MASK) mask_nxt = pwdata[2:0];
    if (wr && paddr == `OFS_IRQ_SET) mask_nxt = mask_r | pwdata[2:0];
    if (wr && paddr == `OFS_IRQ_CLR) mask_nxt = mask_r & ~pwdata[2:0];
    if (wr && paddr == `OFS_MOD_EN) en_nxt = pwdata[0];
    if (wr && paddr == `OFS_ROUTING) route_nxt = pwdata[1:0];
    if (wr && paddr == `OFS_GAIN_L) gain_nxt = pwdata[6:0];
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= 3'h0;
      en_r <= 1'h0;
      route_r <= 2'h0;
      gain_r <= `GAIN_RST;
    end else begin
      mask_r <= mask_nxt;
      en_r <= en_nxt;
      route_r <= route_nxt;
      gain_r <= gain_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  enset_read_a: assert property (
    rd && paddr == `OFS_IRQ_SET |-> prdata == {29'h0, mask_r})
    else $error("Enable-set read wrong");
  enclr_read_a: assert property (
    rd && paddr == `OFS_IRQ_CLR |-> prdata == {29'h0, mask_r})
    else $error("Enable-clear read wrong");
  mask_read_a: assert property (
    rd && paddr == `OFS_IRQ_MASK |-> prdata == {29'h0, mask_r})
    else $error("Mask read wrong");
  irq_masked_a: assert property (
    irq |-> mask_r != 3'h0)
    else $error("Interrupt with all enables off");
  clear_quiet_a: assert property (
    wr && paddr == `OFS_IRQ_CLR && pwdata[2:0] == 3'h7 |=> !irq [*2])
    else $error("Interrupt after all enables cleared");
  gain_read_a: assert property (
    rd && paddr == `OFS_GAIN_L |-> prdata == {25'h0, gain_r})
    else $error("Gain read wrong");
  route_read_a: assert property (
    rd && paddr == `OFS_ROUTING |-> prdata == {30'h0, route_r})
    else $error("Routing read wrong");
  enable_read_a: assert property (
    rd && paddr == `OFS_MOD_EN |-> prdata == {31'h0, en_r})
    else $error("Enable read wrong");
  clock_off_a: assert property (
    !en_r && !$past(en_r) |-> !micBitClock)
    else $error("Mic clock runs while disabled");
  // A disable may abandon a word, so that cycle is left out
  word_hold_a: assert property (
    memWrReq && !memWrAck && en_r && !(wr && paddr == `OFS_MOD_EN)
    |=> memWrReq && $stable(memWrAddr) && $stable(memWrData))
    else $error("Memory word changed before it was taken");
  cover property (wr && paddr == `OFS_TASK_START);
  cover property (memWrReq && memWrAck);
  cover property ($rose(irq));
endmodule
bind pdm_mic_capture_control pdm_mic_checker chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .micBitClock(micBitClock),
  .micDataIn(micDataIn), .memWrReq(memWrReq), .memWrAddr(memWrAddr),
  .memWrData(memWrData), .memWrAck(memWrAck), .irq(irq)
);

// *** tb/pdm_mic_model.sv ***
// Pair of PDM microphones sharing one data line.
// Assumes the block under test drives the mic clock.
`timescale 1ns/10ps
module pdm_mic_model #(
  parameter logic LEFT_LEVEL  = 1'b1,
  parameter logic RIGHT_LEVEL = 1'b0
) (
  // Mic link
  input  wire logic micBitClock,
  output logic      micDataIn
);
  // Left drives while the clock is high, right while low, so each bit
  // is steady up to the edge where it is taken and changes at that edge
  assign micDataIn = micBitClock ? LEFT_LEVEL : RIGHT_LEVEL;
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the capture control block.
// Assumes the mic pair model and the bound checker.
`timescale 1ns/10ps
`include "pdm_mic_regs.svh"
module tb;
  logic        clk_sys, reset_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, memWrAddr, memWrData;
  logic        pready, pslverr, micBitClock, micDataIn;
  logic        memWrReq, memWrAck, irq, lastErr;
  logic [1:0]  stall;
  logic [31:0] qA[$];
  logic [31:0] qD[$];
  logic [31:0] cfgMode[5];
  logic [31:0] cfgGain[5];
  logic [31:0] cfgWord[5];
  int          errTotal = 0, testsRun = 0, cycles = 0;
  pdm_mic_capture_control dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .micBitClock(micBitClock), .micDataIn(micDataIn),
    .memWrReq(memWrReq), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .memWrAck(memWrAck), .irq(irq));
  pdm_mic_model mic_u (.micBitClock(micBitClock), .micDataIn(micDataIn));
  always #20 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////
  // Slow memory: a word waits three cycles before it is taken
  always @(posedge clk_sys) begin
    if (memWrReq && !memWrAck && stall == 2'h2) begin
      memWrAck <= 1'h1;
      qA.push_back(memWrAddr);
      qD.push_back(memWrData);
    end else begin
      memWrAck <= 1'h0;
    end
    stall <= (memWrReq && !memWrAck && stall != 2'h2) ? stall + 2'h1 : 2'h0;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errTotal++;
      $display("MISMATCH %0t run too long", $time);
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'h1, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(a, 1'h0, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic get_word(output logic [31:0] a, output logic [31:0] d);
    int n;
    n = 0;
    while (qA.size() == 0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    a = (qA.size() != 0) ? qA.pop_front() : 32'h0;
    d = (qD.size() != 0) ? qD.pop_front() : 32'hdead0bad;
  endtask
  // Polls the status word, which clears on read, twelve times and checks stop and end have landed
  task automatic stop_cap();
    logic [31:0] acc, r;
    acc = 32'h0;
    wr(`OFS_TASK_STOP, 32'h1);
    repeat (12) begin
      apb(`OFS_IRQ_STATUS, 1'h0, 32'h0, r);
      acc = acc | r;
    end
    chk({30'h0, acc[2:1]}, 32'h3);
    chk({31'h0, micBitClock}, 32'h0);
    qA.delete();
    qD.delete();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] a, d;
    {clk_sys, reset_n, psel, penable, pwrite} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cfgMode = '{32'h0, 32'h2, 32'h1, 32'h1, 32'h3};
    cfgGain = '{32'h28, 32'h50, 32'h50, 32'h0, 32'h28};
    cfgWord = '{32'hfb000500, 32'h0500f600, 32'h0a000a00, 32'h0,
                32'hfb00fb00};
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    rd(`OFS_IRQ_SET, 32'h0);
    rd(`OFS_MOD_EN, 32'h0);
    rd(`OFS_ROUTING, 32'h0);
    rd(`OFS_GAIN_L, {25'h0, `GAIN_RST});
    rd(`OFS_CLK_CTRL, 32'(`MIC_HALF_CYC));
    apb(12'h200, 1'h0, 32'h0, d);
    chk({31'h0, lastErr}, 32'h1);
    // Set and clear enables; zero writes change nothing
    wr(`OFS_IRQ_SET, 32'h5);
    rd(`OFS_IRQ_CLR, 32'h5);
    wr(`OFS_IRQ_CLR, 32'h1);
    wr(`OFS_IRQ_SET, 32'h0);
    wr(`OFS_IRQ_CLR, 32'h0);
    rd(`OFS_IRQ_MASK, 32'h4);
    wr(`OFS_IRQ_MASK, 32'h7);
    wr(`OFS_IRQ_CLR, 32'h7);
    // Start is ignored while disabled
    wr(`OFS_TASK_START, 32'h1);
    repeat (20) @(posedge clk_sys);
    rd(`OFS_IRQ_STATUS, 32'h0);
    // Stereo capture over a two-word buffer that wraps
    wr(`OFS_MOD_EN, 32'h1);
    wr(`OFS_RAM_PTR, 32'h1000);
    wr(`OFS_CNT_LIMIT, 32'h4);
    wr(`OFS_IRQ_SET, 32'h1);
    wr(`OFS_TASK_START, 32'h1);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_CLR, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(`OFS_EVT_STARTED, 32'h1);
    rd(`OFS_EVT_STARTED, 32'h0);
    wr(`OFS_IRQ_SET, 32'h4);
    get_word(a, d);
    chk(a, 32'h1000);
    chk(d, 32'hfb000500);
    get_word(a, d);
    chk(a, 32'h1004);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rd(`OFS_EVT_END, 32'h1);
    get_word(a, d);
    chk(a, 32'h1000);
    stop_cap();
    // Every routing mode and edge, gain at both ends of its range
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_ROUTING, cfgMode[i]);
      wr(`OFS_GAIN_L, cfgGain[i]);
      wr(`OFS_TASK_START, 32'h1);
      get_word(a, d);
      chk(d, cfgWord[i]);
      stop_cap();
    end
    wrap_up();
  end
endmodule
